// file: logic/frame_packer.sv
// Transport frame packer with AHB-Lite control registers
//
// How it works
// - Parameters that are at least one are stored and reported as value minus one.
// - Every mode reports two converters, 12 bits, no control words or bits, HD off.
// - Three-lane efficient: L=3, F=6, S=6, N'=12, K at least 3.
// - Three-lane: lane 0 C0 S0-S3, lane 1 C0 S4-S5 then C1 S0-S1.
// - Three-lane: lane 2 carries C1 samples 2 to 5 in pairs.
// - Two-lane efficient: F=3, S=2, K at least 6, one converter pair per lane.
// - Two-lane simple: F=2, S=1, N'=16, K at least 9, high byte then nibble+tail.
// - One-lane efficient: F=6, S=2, K at least 3, C0 pair then C1 pair.
// - One-lane simple: F=4, S=1, N'=16, K at least 5, C0 then C1.
// - Tail bits carry no information; they are sent as a constant.
// - Lane 0 is the first lane; lane 2 exists only with three lanes.
// - Reset selects efficient packing; simple only after reprogramming.
// - Full parameter set of the active mode, K raised to at least its minimum, is presented for the alignment multiframe.
`timescale 1ns/1ps
module frame_packer
   import frame_pack_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire logic sample_valid,
   output logic sample_ready,
   input wire logic [SAMPLE_W-1:0] conv0_sample,
   input wire logic [SAMPLE_W-1:0] conv1_sample,
   output logic frame_valid,
   input wire logic frame_ready,
   output logic [LANE_W-1:0] lane0_octets,
   output logic [LANE_W-1:0] lane1_octets,
   output logic [LANE_W-1:0] lane2_octets,
   output logic [2:0] frame_mode,
   output logic [31:0] ila_param0,
   output logic [31:0] ila_param1
);
   localparam int BUF_W = LANES*LANE_W + 3;

   ////////////////////////////////////////////////////////////////////////////
   // Bus slave

   logic wr_pend_reg;
   logic [7:0] wr_addr_reg;
   logic [31:0] hrdata_reg;
   pack_mode_e mode_reg;
   logic [ENC_W-1:0] k_reg;
   pack_mode_e act_mode_reg;
   logic [15:0] frame_cnt_reg;
   logic [31:0] ila0_reg;
   logic [31:0] ila1_reg;

   wire addr_phase = hsel && htrans[1] && hready;
   wire [7:0] a_ofs = haddr[7:0];
   wire wr_ctrl = wr_pend_reg && (wr_addr_reg == OFS_CTRL);
   wire [2:0] wr_mode = hwdata[CTRL_MODE_LSB +: 3];
   wire [ENC_W-1:0] wr_k = hwdata[CTRL_K_LSB +: ENC_W];
   // Unknown mode codes are dropped rather than risk an undefined frame map
   wire mode_ok = (wr_mode <= MODE_SIM1);

   logic [7:0] f_enc;
   logic [ENC_W-1:0] l_enc;
   logic [ENC_W-1:0] s_enc;
   logic [ENC_W-1:0] np_enc;
   logic [ENC_W-1:0] kmin_enc;

   frame_param_table u_table (
      .mode(act_mode_reg),
      .f_enc(f_enc),
      .l_enc(l_enc),
      .s_enc(s_enc),
      .np_enc(np_enc),
      .kmin_enc(kmin_enc)
   );

   // Link parameter K never reported below the least legal value for the active mode
   wire [ENC_W-1:0] k_eff = (k_reg < kmin_enc) ? kmin_enc : k_reg;

   wire [31:0] param0 = (32'(f_enc) << P0_F_LSB)
      | (32'(l_enc) << P0_L_LSB)
      | (32'(ENC_M) << P0_M_LSB)
      | (32'(k_eff) << P0_K_LSB);
   wire [31:0] param1 = (32'(ENC_N) << P1_N_LSB)
      | (32'(np_enc) << P1_NP_LSB)
      | (32'(s_enc) << P1_S_LSB)
      | (32'(ENC_CF) << P1_CF_LSB)
      | (32'(ENC_CS) << P1_CS_LSB)
      | (32'(ENC_HD) << P1_HD_LSB);

   logic pend_reg;
   logic buf_in_ready;
   logic buf_out_valid;

   wire [31:0] ctrl_rd = (32'(mode_reg) << CTRL_MODE_LSB) | (32'(k_reg) << CTRL_K_LSB);
   wire [31:0] status_rd = (32'(frame_cnt_reg) << ST_COUNT_LSB)
      | (32'(act_mode_reg) << ST_MODE_LSB)
      | (32'(pend_reg) << ST_PEND_LSB)
      | (32'(!buf_in_ready) << ST_FULL_LSB);
   wire [31:0] rd_mux = (a_ofs == OFS_CTRL) ? ctrl_rd :
      (a_ofs == OFS_PARAM0) ? param0 :
      (a_ofs == OFS_PARAM1) ? param1 :
      (a_ofs == OFS_STATUS) ? status_rd : 32'h0000_0000;

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         wr_pend_reg <= 1'b0;
         wr_addr_reg <= 8'h00;
         hrdata_reg <= 32'h0000_0000;
      end
      else
      begin
         wr_pend_reg <= addr_phase && hwrite;
         if (addr_phase)
            wr_addr_reg <= a_ofs;
         if (addr_phase && !hwrite)
            hrdata_reg <= rd_mux;
      end
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         mode_reg <= RESET_MODE;
         k_reg <= RESET_K;
      end
      else if (wr_ctrl)
      begin
         if (mode_ok)
            mode_reg <= pack_mode_e'(wr_mode);
         k_reg <= wr_k;
      end
   end

   assign hrdata = hrdata_reg;
   // Zero wait states and always OKAY
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;

   ////////////////////////////////////////////////////////////////////////////
   // Sample gathering

   logic [SAMPLE_W-1:0] c0_reg [MAX_S];
   logic [SAMPLE_W-1:0] c1_reg [MAX_S];
   logic [IDX_W-1:0] idx_reg;
   logic sready_reg;

   wire accept = sample_valid && sready_reg;
   wire last_sample = (idx_reg == s_enc[IDX_W-1:0]);
   wire push = pend_reg && buf_in_ready;
   // A new mode only takes effect between frames so no frame mixes two maps
   wire frame_idle = (idx_reg == '0) && !pend_reg;
   wire pend_next = (accept && last_sample) || (pend_reg && !buf_in_ready);

   genvar gi;
   generate
      for (gi = 0; gi < MAX_S; gi++)
      begin : g_slot
         always_ff @(posedge hclk or negedge hresetn)
         begin
            if (!hresetn)
            begin
               c0_reg[gi] <= '0;
               c1_reg[gi] <= '0;
            end
            else if (accept && idx_reg == IDX_W'(gi))
            begin
               c0_reg[gi] <= conv0_sample;
               c1_reg[gi] <= conv1_sample;
            end
         end
      end
   endgenerate

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         idx_reg <= '0;
         pend_reg <= 1'b0;
         sready_reg <= 1'b0;
         act_mode_reg <= RESET_MODE;
         frame_cnt_reg <= 16'h0000;
      end
      else
      begin
         if (accept)
            idx_reg <= last_sample ? '0 : idx_reg + 1'b1;
         pend_reg <= pend_next;
         sready_reg <= !pend_next;
         if (frame_idle && !accept)
            act_mode_reg <= mode_reg;
         if (push)
            frame_cnt_reg <= frame_cnt_reg + 16'h0001;
      end
   end

   assign sample_ready = sready_reg;

   ////////////////////////////////////////////////////////////////////////////
   // Frame map

   function automatic logic [PAIR_W-1:0] pair_pack(input logic [SAMPLE_W-1:0] a,
                                                   input logic [SAMPLE_W-1:0] b);
      pair_pack = {a[11:4], a[3:0], b[11:8], b[7:0]};
   endfunction

   function automatic logic [SIMPLE_W-1:0] simple_pack(input logic [SAMPLE_W-1:0] a);
      simple_pack = {a[11:4], a[3:0], TAIL_BITS};
   endfunction

   wire [PAIR_W-1:0] p0_01 = pair_pack(c0_reg[0], c0_reg[1]);
   wire [PAIR_W-1:0] p0_23 = pair_pack(c0_reg[2], c0_reg[3]);
   wire [PAIR_W-1:0] p0_45 = pair_pack(c0_reg[4], c0_reg[5]);
   wire [PAIR_W-1:0] p1_01 = pair_pack(c1_reg[0], c1_reg[1]);
   wire [PAIR_W-1:0] p1_23 = pair_pack(c1_reg[2], c1_reg[3]);
   wire [PAIR_W-1:0] p1_45 = pair_pack(c1_reg[4], c1_reg[5]);
   wire [SIMPLE_W-1:0] s0 = simple_pack(c0_reg[0]);
   wire [SIMPLE_W-1:0] s1 = simple_pack(c1_reg[0]);
   localparam logic [PAIR_W-1:0] PAD_PAIR = '0;
   localparam logic [LANE_W-SIMPLE_W-1:0] PAD_S1 = '0;
   localparam logic [LANE_W-2*SIMPLE_W-1:0] PAD_S2 = '0;

   logic [LANE_W-1:0] lane0_map;
   logic [LANE_W-1:0] lane1_map;
   logic [LANE_W-1:0] lane2_map;

   // Octet 0 of each lane sits in the top byte; unused lanes send zeros
   always_comb
   begin
      lane0_map = '0;
      lane1_map = '0;
      lane2_map = '0;
      case (act_mode_reg)
         MODE_EFF3:
         begin
            lane0_map = {p0_01, p0_23};
            lane1_map = {p0_45, p1_01};
            lane2_map = {p1_23, p1_45};
         end
         MODE_EFF2:
         begin
            lane0_map = {p0_01, PAD_PAIR};
            lane1_map = {p1_01, PAD_PAIR};
         end
         MODE_SIM2:
         begin
            lane0_map = {s0, PAD_S1};
            lane1_map = {s1, PAD_S1};
         end
         MODE_EFF1:
            lane0_map = {p0_01, p1_01};
         MODE_SIM1:
            lane0_map = {s0, s1, PAD_S2};
         default:
            lane0_map = '0;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // Output buffer and alignment parameters

   logic [BUF_W-1:0] buf_out;

   frame_buffer2 #(
      .WIDTH(BUF_W)
   ) u_buf (
      .hclk(hclk),
      .hresetn(hresetn),
      .in_valid(pend_reg),
      .in_ready(buf_in_ready),
      .in_data({3'(act_mode_reg), lane0_map, lane1_map, lane2_map}),
      .out_valid(buf_out_valid),
      .out_ready(frame_ready),
      .out_data(buf_out)
   );

   assign frame_valid = buf_out_valid;
   assign lane0_octets = buf_out[2*LANE_W +: LANE_W];
   assign lane1_octets = buf_out[LANE_W +: LANE_W];
   assign lane2_octets = buf_out[0 +: LANE_W];
   assign frame_mode = buf_out[LANES*LANE_W +: 3];

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         ila0_reg <= 32'h0000_0000;
         ila1_reg <= 32'h0000_0000;
      end
      else
      begin
         ila0_reg <= param0;
         ila1_reg <= param1;
      end
   end

   assign ila_param0 = ila0_reg;
   assign ila_param1 = ila1_reg;
endmodule // frame_packer

// file: inc/frame_pack_pkg.sv
// Constants, modes and register map of the transport frame packer
package frame_pack_pkg;
   typedef enum logic [2:0] {
      MODE_EFF3 = 3'b000,
      MODE_EFF2 = 3'b001,
      MODE_SIM2 = 3'b010,
      MODE_EFF1 = 3'b011,
      MODE_SIM1 = 3'b100
   } pack_mode_e;
   localparam pack_mode_e RESET_MODE = MODE_EFF3;
   // Sample and frame geometry
   localparam int SAMPLE_W = 12;
   localparam int OCTET_W = 8;
   localparam int LANE_W = 48;
   localparam int LANES = 3;
   localparam int MAX_S = 6;
   localparam int IDX_W = 3;
   localparam int PAIR_W = 24;
   localparam int SIMPLE_W = 16;
   localparam logic [3:0] TAIL_BITS = 4'h0;
   // Encoded link parameters (actual value minus one; CF, CS and HD as is)
   localparam int ENC_W = 5;
   localparam logic [ENC_W-1:0] ENC_M = 5'h01;
   localparam logic [ENC_W-1:0] ENC_N = 5'h0b;
   localparam logic [ENC_W-1:0] ENC_CF = 5'h00;
   localparam logic [1:0] ENC_CS = 2'h0;
   localparam logic ENC_HD = 1'b0;
   localparam logic [ENC_W-1:0] ENC_NP_EFF = 5'h0b;
   localparam logic [ENC_W-1:0] ENC_NP_SIM = 5'h0f;
   localparam logic [7:0] ENC_F_6 = 8'h05;
   localparam logic [7:0] ENC_F_4 = 8'h03;
   localparam logic [7:0] ENC_F_3 = 8'h02;
   localparam logic [7:0] ENC_F_2 = 8'h01;
   localparam logic [ENC_W-1:0] ENC_L_3 = 5'h02;
   localparam logic [ENC_W-1:0] ENC_L_2 = 5'h01;
   localparam logic [ENC_W-1:0] ENC_L_1 = 5'h00;
   localparam logic [ENC_W-1:0] ENC_S_6 = 5'h05;
   localparam logic [ENC_W-1:0] ENC_S_2 = 5'h01;
   localparam logic [ENC_W-1:0] ENC_S_1 = 5'h00;
   localparam logic [ENC_W-1:0] ENC_KMIN_3 = 5'h02;
   localparam logic [ENC_W-1:0] ENC_KMIN_6 = 5'h05;
   localparam logic [ENC_W-1:0] ENC_KMIN_9 = 5'h08;
   localparam logic [ENC_W-1:0] ENC_KMIN_5 = 5'h04;
   localparam logic [ENC_W-1:0] RESET_K = 5'h1f;
   // Register map, byte addresses
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_PARAM0 = 8'h04;
   localparam logic [7:0] OFS_PARAM1 = 8'h08;
   localparam logic [7:0] OFS_STATUS = 8'h0c;
   // Field positions
   localparam int CTRL_MODE_LSB = 0;
   localparam int CTRL_K_LSB = 8;
   localparam int P0_F_LSB = 0;
   localparam int P0_L_LSB = 8;
   localparam int P0_M_LSB = 16;
   localparam int P0_K_LSB = 24;
   localparam int P1_N_LSB = 0;
   localparam int P1_NP_LSB = 8;
   localparam int P1_S_LSB = 16;
   localparam int P1_CF_LSB = 24;
   localparam int P1_CS_LSB = 29;
   localparam int P1_HD_LSB = 31;
   localparam int ST_COUNT_LSB = 0;
   localparam int ST_MODE_LSB = 16;
   localparam int ST_PEND_LSB = 20;
   localparam int ST_FULL_LSB = 21;
endpackage

// file: logic/frame_param_table.sv
// Link parameter table per packing mode
`timescale 1ns/1ps
module frame_param_table
   import frame_pack_pkg::*;
(
   input wire pack_mode_e mode,
   output logic [7:0] f_enc,
   output logic [ENC_W-1:0] l_enc,
   output logic [ENC_W-1:0] s_enc,
   output logic [ENC_W-1:0] np_enc,
   output logic [ENC_W-1:0] kmin_enc
);
   always_comb
   begin
      case (mode)
         MODE_EFF2:
         begin
            f_enc = ENC_F_3;
            l_enc = ENC_L_2;
            s_enc = ENC_S_2;
            np_enc = ENC_NP_EFF;
            kmin_enc = ENC_KMIN_6;
         end
         MODE_SIM2:
         begin
            f_enc = ENC_F_2;
            l_enc = ENC_L_2;
            s_enc = ENC_S_1;
            np_enc = ENC_NP_SIM;
            kmin_enc = ENC_KMIN_9;
         end
         MODE_EFF1:
         begin
            f_enc = ENC_F_6;
            l_enc = ENC_L_1;
            s_enc = ENC_S_2;
            np_enc = ENC_NP_EFF;
            kmin_enc = ENC_KMIN_3;
         end
         MODE_SIM1:
         begin
            f_enc = ENC_F_4;
            l_enc = ENC_L_1;
            s_enc = ENC_S_1;
            np_enc = ENC_NP_SIM;
            kmin_enc = ENC_KMIN_5;
         end
         default:
         begin
            f_enc = ENC_F_6;
            l_enc = ENC_L_3;
            s_enc = ENC_S_6;
            np_enc = ENC_NP_EFF;
            kmin_enc = ENC_KMIN_3;
         end
      endcase
   end
endmodule // frame_param_table

// file: logic/frame_buffer2.sv
// Two-entry buffer with valid/ready on both sides, head drives output
`timescale 1ns/1ps
module frame_buffer2 #(
   parameter int WIDTH = 8
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   logic [WIDTH-1:0] head_reg;
   logic [WIDTH-1:0] tail_reg;
   logic head_v_reg;
   logic tail_v_reg;
   wire push = in_valid && !tail_v_reg;
   wire pop = head_v_reg && out_ready;
   assign in_ready = !tail_v_reg;
   assign out_valid = head_v_reg;
   assign out_data = head_reg;

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         head_v_reg <= 1'b0;
         tail_v_reg <= 1'b0;
         head_reg <= '0;
         tail_reg <= '0;
      end
      else
      begin
         // Head refills from tail first so order is kept
         if (!head_v_reg || pop)
         begin
            head_v_reg <= tail_v_reg || push;
            head_reg <= tail_v_reg ? tail_reg : in_data;
            tail_v_reg <= tail_v_reg && push;
            if (tail_v_reg && push)
               tail_reg <= in_data;
         end
         else if (push)
         begin
            tail_v_reg <= 1'b1;
            tail_reg <= in_data;
         end
      end
   end
endmodule // frame_buffer2

// file: sim/frame_packer_properties.sv
// Port-level assertions for the frame packer
`timescale 1ns/1ps
module frame_packer_checker (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic [31:0] hrdata,
   input wire logic sample_valid,
   input wire logic sample_ready,
   input wire logic [11:0] conv0_sample,
   input wire logic [11:0] conv1_sample,
   input wire logic frame_valid,
   input wire logic frame_ready,
   input wire logic [47:0] lane0_octets,
   input wire logic [47:0] lane1_octets,
   input wire logic [47:0] lane2_octets,
   input wire logic [2:0] frame_mode,
   input wire logic [31:0] ila_param0,
   input wire logic [31:0] ila_param1
);
   import frame_pack_pkg::*;
   default clocking dcb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   ////////////////////////////////////////////////////////////////////////////////
   property p_reset_eff3;
      $rose(hresetn) |=> ila_param0[12:0] == {ENC_L_3, ENC_F_6} && ila_param1[20:16] == ENC_S_6;
   endproperty
   a_reset_eff3: assert property (p_reset_eff3) else $error("not three-lane after reset");
   // Guarded by the past reset: the copies are still zero at the first edge
   property p_fixed;
      $past(hresetn) |-> ila_param1[4:0] == ENC_N && ila_param1[31:24] == 8'h00 && ila_param0[20:16] == ENC_M;
   endproperty
   a_fixed: assert property (p_fixed) else $error("fixed link fields wrong");
   property p_np_by_f;
      $past(hresetn) && (ila_param0[7:0] == ENC_F_2 || ila_param0[7:0] == ENC_F_4) |-> ila_param1[12:8] == ENC_NP_SIM;
   endproperty
   a_np_by_f: assert property (p_np_by_f) else $error("simple mode without 16-bit words");
   property p_k_min;
      $past(hresetn) |-> ila_param0[28:24] >= (ila_param0[7:0] == ENC_F_2 ? ENC_KMIN_9 :
         ila_param0[7:0] == ENC_F_4 ? ENC_KMIN_5 : ila_param0[7:0] == ENC_F_3 ? ENC_KMIN_6 : ENC_KMIN_3);
   endproperty
   a_k_min: assert property (p_k_min) else $error("K below mode minimum");
   property p_simple2;
      frame_valid && frame_mode == MODE_SIM2 |-> lane0_octets[35:0] == 36'h0 && lane1_octets[35:0] == 36'h0
         && lane2_octets == 48'h0;
   endproperty
   a_simple2: assert property (p_simple2) else $error("two-lane simple tail or pad not zero");
   property p_simple1;
      frame_valid && frame_mode == MODE_SIM1 |-> lane0_octets[35:32] == 4'h0 && lane0_octets[19:0] == 20'h0
         && lane1_octets == 48'h0 && lane2_octets == 48'h0;
   endproperty
   a_simple1: assert property (p_simple1) else $error("one-lane simple tail or pad not zero");
   property p_eff_unused;
      frame_valid && (frame_mode == MODE_EFF1 || frame_mode == MODE_EFF2) |-> lane2_octets == 48'h0
         && (frame_mode == MODE_EFF1 ? lane1_octets == 48'h0 : lane0_octets[23:0] == 24'h0);
   endproperty
   a_eff_unused: assert property (p_eff_unused) else $error("unused lane not zero");
   property p_hold;
      frame_valid && !frame_ready |=> frame_valid && $stable(lane0_octets) && $stable(lane1_octets)
         && $stable(lane2_octets) && $stable(frame_mode);
   endproperty
   a_hold: assert property (p_hold) else $error("frame changed while stalled");
   property p_okay;
      hreadyout && !hresp;
   endproperty
   a_okay: assert property (p_okay) else $error("slave not ready or not OKAY");
   c_eff3: cover property (frame_valid && frame_ready && frame_mode == MODE_EFF3);
   c_sim1: cover property (frame_valid && frame_ready && frame_mode == MODE_SIM1);
   c_stall: cover property (sample_valid && !sample_ready && frame_valid && !frame_ready);
endmodule // frame_packer_checker

bind frame_packer frame_packer_checker chk_u (
   .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
   .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
   .sample_valid(sample_valid), .sample_ready(sample_ready), .conv0_sample(conv0_sample),
   .conv1_sample(conv1_sample), .frame_valid(frame_valid), .frame_ready(frame_ready),
   .lane0_octets(lane0_octets), .lane1_octets(lane1_octets), .lane2_octets(lane2_octets),
   .frame_mode(frame_mode), .ila_param0(ila_param0), .ila_param1(ila_param1)
);

// file: sim/frame_receiver.sv
// Behavioural frame receiver on the far side of the packer
`timescale 1ns/1ps
module frame_receiver (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic slow,
   input wire logic hold,
   input wire logic frame_valid,
   input wire logic [2:0] frame_mode,
   input wire logic [47:0] lane0_octets,
   input wire logic [47:0] lane1_octets,
   input wire logic [47:0] lane2_octets,
   output logic frame_ready
);
   logic [1:0] beat_reg;
   logic [146:0] got_q[$];
   ////////////////////////////////////////////////////////////////////////////////
   // Slow takes one frame in four cycles, so the packer must absorb the stall
   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         beat_reg <= 2'h0;
         frame_ready <= 1'b0;
      end
      else
      begin
         if (frame_valid && frame_ready)
            got_q.push_back({frame_mode, lane0_octets, lane1_octets, lane2_octets});
         beat_reg <= beat_reg + 2'h1;
         frame_ready <= !hold && (!slow || beat_reg == 2'h3);
      end
   end
endmodule // frame_receiver

// file: sim/tb.sv
// Self-checking bench for the frame packer
`timescale 1ns/1ps
module tb;
   import frame_pack_pkg::*;
   logic hclk, hresetn, hsel, hwrite, sample_valid, slow, hold;
   logic hready, hreadyout, hresp, sample_ready, frame_valid, frame_ready;
   logic [1:0] htrans;
   logic [2:0] hsize, frame_mode;
   logic [31:0] haddr, hwdata, hrdata, rd, ila_param0, ila_param1, p0e, p1e;
   logic [SAMPLE_W-1:0] conv0_sample, conv1_sample;
   logic [SAMPLE_W-1:0] a[6], b[6];
   logic [LANE_W-1:0] lane0_octets, lane1_octets, lane2_octets;
   logic [146:0] exp_q[$];
   int error_cnt = 0, comparisons = 0, cyc = 0, acc;
   // Link parameters by mode code
   logic [7:0] f_t[5] = '{8'h05, 8'h02, 8'h01, 8'h05, 8'h03};
   logic [4:0] l_t[5] = '{5'h02, 5'h01, 5'h01, 5'h00, 5'h00};
   logic [4:0] s_t[5] = '{5'h05, 5'h01, 5'h00, 5'h01, 5'h00};
   logic [4:0] np_t[5] = '{5'h0b, 5'h0b, 5'h0f, 5'h0b, 5'h0f};
   logic [4:0] k_t[5] = '{5'h02, 5'h05, 5'h08, 5'h02, 5'h04};
   int sn_t[5] = '{6, 2, 1, 2, 1};
   assign hready = hreadyout;
   frame_packer dut_u (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
      .sample_valid(sample_valid), .sample_ready(sample_ready), .conv0_sample(conv0_sample),
      .conv1_sample(conv1_sample), .frame_valid(frame_valid), .frame_ready(frame_ready),
      .lane0_octets(lane0_octets), .lane1_octets(lane1_octets), .lane2_octets(lane2_octets),
      .frame_mode(frame_mode), .ila_param0(ila_param0), .ila_param1(ila_param1)
   );
   frame_receiver rx_u (
      .hclk(hclk), .hresetn(hresetn), .slow(slow), .hold(hold), .frame_valid(frame_valid),
      .frame_mode(frame_mode), .lane0_octets(lane0_octets), .lane1_octets(lane1_octets),
      .lane2_octets(lane2_octets), .frame_ready(frame_ready)
   );
   ////////////////////////////////////////////////////////////////////////////////
   function automatic logic [23:0] pr(input logic [11:0] x, input logic [11:0] y);
      return {x[11:4], x[3:0], y[11:8], y[7:0]};
   endfunction
   function automatic logic [15:0] sp(input logic [11:0] x);
      return {x[11:4], x[3:0], TAIL_BITS};
   endfunction
   function automatic logic [146:0] exp_frame(input logic [2:0] m);
      case (m)
         MODE_EFF3: return {m, pr(a[0], a[1]), pr(a[2], a[3]), pr(a[4], a[5]), pr(b[0], b[1]), pr(b[2], b[3]),
            pr(b[4], b[5])};
         MODE_EFF2: return {m, pr(a[0], a[1]), 24'h0, pr(b[0], b[1]), 24'h0, 48'h0};
         MODE_SIM2: return {m, sp(a[0]), 32'h0, sp(b[0]), 32'h0, 48'h0};
         MODE_EFF1: return {m, pr(a[0], a[1]), pr(b[0], b[1]), 96'h0};
         default: return {m, sp(a[0]), sp(b[0]), 16'h0, 96'h0};
      endcase
   endfunction
   task automatic chk(input logic [146:0] got, input logic [146:0] exp, input string what);
      comparisons++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("MISMATCH %0t %s got %0h exp %0h", $time, what, got, exp);
      end
   endtask
   task stop_test();
      $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   // Single word transfer; the wait loops never assume a fixed latency
   task automatic ahb(input logic w, input logic [7:0] ad, input logic [31:0] wd, output logic [31:0] r);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {24'h0, ad};
      hwrite <= w;
      do @(posedge hclk); while (hready !== 1'b1);
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge hclk); while (hready !== 1'b1);
      r = hrdata;
   endtask
   task automatic send_frame(input logic [2:0] m, input int f, input int s);
      for (int i = 0; i < s; i++)
      begin
         a[i] = 12'h9c3 ^ {4'(f), 4'(i), 4'h0};
         b[i] = 12'h36a ^ {4'(i), 4'(f), 4'h5};
         sample_valid <= 1'b1;
         conv0_sample <= a[i];
         conv1_sample <= b[i];
         do @(posedge hclk); while (sample_ready !== 1'b1);
      end
      exp_q.push_back(exp_frame(m));
   endtask
   task automatic drain();
      int n = 0;
      while (rx_u.got_q.size() < exp_q.size() && n < 3000)
      begin
         @(posedge hclk);
         n++;
      end
      while (exp_q.size() > 0)
         chk(rx_u.got_q.size() > 0 ? rx_u.got_q.pop_front() : '0, exp_q.pop_front(), "frame");
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      hclk = 1'b0;
      forever #4 hclk = ~hclk;
   end
   always @(posedge hclk)
   begin
      cyc = cyc + 1;
      if (cyc == 20000)
      begin
         error_cnt = error_cnt + 1;
         stop_test();
      end
   end
   initial
   begin
      {hresetn, hsel, hwrite, sample_valid, slow, hold, htrans, haddr, hwdata} = '0;
      hsize = 3'h2;
      conv0_sample = '0;
      conv1_sample = '0;
      repeat (8) @(posedge hclk);
      hresetn <= 1'b1;
      ahb(1'b0, OFS_CTRL, 32'h0, rd);
      chk(rd, 32'h00001f00, "ctrl reset");
      ahb(1'b0, OFS_PARAM0, 32'h0, rd);
      chk(rd, 32'h1f010205, "param0 reset");
      ahb(1'b0, OFS_PARAM1, 32'h0, rd);
      chk(rd, 32'h00050b0b, "param1 reset");
      ahb(1'b0, 8'h10, 32'h0, rd);
      chk(rd, 32'h0, "unmapped");
      $display("test reset done");
      for (int m = 0; m < 5; m++)
      begin
         p0e = {3'h0, k_t[m], 3'h0, ENC_M, 3'h0, l_t[m], f_t[m]};
         p1e = {8'h00, 3'h0, s_t[m], 3'h0, np_t[m], 3'h0, ENC_N};
         ahb(1'b1, OFS_CTRL, {29'h0, 3'(m)}, rd);
         ahb(1'b0, OFS_PARAM0, 32'h0, rd);
         chk(rd, p0e, "param0");
         ahb(1'b0, OFS_PARAM1, 32'h0, rd);
         chk(rd, p1e, "param1");
         slow <= (m % 2) == 1;
         send_frame(3'(m), 2 * m, sn_t[m]);
         send_frame(3'(m), 2 * m + 1, sn_t[m]);
         sample_valid <= 1'b0;
         drain();
         chk({ila_param1, ila_param0}, {p1e, p0e}, "ila");
         ahb(1'b0, OFS_STATUS, 32'h0, rd);
         chk(rd[21:0], {3'b000, 3'(m), 16'(2 * m + 2)}, "status mode");
         $display("test mode %0d done", m);
      end
      // Bad mode code keeps simple one-lane but takes the new K
      ahb(1'b1, OFS_CTRL, 32'h00000907, rd);
      ahb(1'b0, OFS_PARAM0, 32'h0, rd);
      chk(rd, 32'h09010003, "ctrl bad mode");
      // Receiver stalls: two frames fill the buffer, a third waits pending, then intake must stop
      hold <= 1'b1;
      send_frame(3'h4, 20, 1);
      send_frame(3'h4, 21, 1);
      acc = 0;
      repeat (12)
      begin
         @(posedge hclk);
         if (sample_ready === 1'b1)
         begin
            acc++;
            exp_q.push_back(exp_frame(3'h4));
         end
      end
      // One frame pending behind two buffered ones, then intake stops
      chk(acc == 1, 1'b1, "stall intake");
      ahb(1'b0, OFS_STATUS, 32'h0, rd);
      chk(rd[21:20], 2'b11, "status stalled");
      chk(rx_u.got_q.size(), 0, "held frames");
      hold <= 1'b0;
      sample_valid <= 1'b0;
      drain();
      $display("test stall done");
      stop_test();
   end
endmodule // tb
